// ==== design/bdbrk_cmp.sv ====
// One breakpoint comparator: two byte compares plus direction qualifier
`timescale 1ns/1ps
`default_nettype none
module bdbrk_cmp (
   input wire logic [15:0] ref_val,
   input wire logic [15:0] cmp_val,
   input wire logic use_hi,
   input wire logic use_lo,
   input wire logic dir_en,
   input wire logic dir_val,
   input wire logic bus_rnw,
   output logic match
);
   wire logic hi_ok;
   wire logic lo_ok;
   wire logic dir_ok;

   assign hi_ok = !use_hi || (cmp_val[15:8] == ref_val[15:8]);
   assign lo_ok = !use_lo || (cmp_val[7:0] == ref_val[7:0]);
   assign dir_ok = !dir_en || (bus_rnw == dir_val);
   assign match = hi_ok && lo_ok && dir_ok;
endmodule : bdbrk_cmp
`default_nettype wire

// ==== design/bdbrk_fwdec.sv ====
// Decoder for the firmware form of the debug command byte
`timescale 1ns/1ps
`default_nettype none
module bdbrk_fwdec (
   input wire logic [7:0] cmd,
   output logic is_fw,
   output bdbrk_pkg::bdbrk_go_t go_sel,
   output logic sel_next,
   output logic sel_pc,
   output logic is_read
);
   import bdbrk_pkg::*;

   assign is_fw = !cmd[CMD_HW_BIT];
   assign go_sel = bdbrk_go_t'(cmd[CMD_GO_MSB:CMD_GO_LSB]);
   assign sel_next = cmd[CMD_REG_MSB:CMD_REG_LSB] == REG_SEL_NEXT;
   assign sel_pc = cmd[CMD_REG_MSB:CMD_REG_LSB] == REG_SEL_PC;
   assign is_read = cmd[CMD_RD_BIT];
endmodule : bdbrk_fwdec
`default_nettype wire

// ==== design/bdbrk_pkg.sv ====
// Shared constants for the background debug and breakpoint block
package bdbrk_pkg;
   // ======================================================
   // Debug register map, active while background is mapped
   localparam logic [15:0] DBG_INSTR_OFS = 16'hFF00;
   localparam logic [15:0] DBG_STATUS_OFS = 16'hFF01;
   localparam logic [15:0] DBG_SHIFT_HI_OFS = 16'hFF02;
   localparam logic [15:0] DBG_SHIFT_LO_OFS = 16'hFF03;
   localparam logic [15:0] DBG_PTR_HI_OFS = 16'hFF04;
   localparam logic [15:0] DBG_PTR_LO_OFS = 16'hFF05;
   localparam logic [15:0] DBG_CCR_OFS = 16'hFF06;
   // ======================================================
   // Breakpoint register map, always mapped
   localparam logic [15:0] BRK_CTL0_OFS = 16'h0020;
   localparam logic [15:0] BRK_CTL1_OFS = 16'h0021;
   localparam logic [15:0] BRK_ADDR_HI_OFS = 16'h0022;
   localparam logic [15:0] BRK_ADDR_LO_OFS = 16'h0023;
   localparam logic [15:0] BRK_DATA_HI_OFS = 16'h0024;
   localparam logic [15:0] BRK_DATA_LO_OFS = 16'h0025;
   // ======================================================
   // Command byte fields
   localparam int CMD_HW_BIT = 7;
   localparam int CMD_RD_BIT = 5;
   localparam int CMD_GO_MSB = 4;
   localparam int CMD_GO_LSB = 3;
   localparam int CMD_REG_MSB = 2;
   localparam int CMD_REG_LSB = 0;
   localparam logic [2:0] REG_SEL_NEXT = 3'h2;
   localparam logic [2:0] REG_SEL_PC = 3'h3;
   // ======================================================
   // Status register bit positions
   localparam int ST_PERMIT_BIT = 7;
   localparam int ST_ACTIVE_BIT = 6;
   localparam int ST_TAG_BIT = 5;
   localparam int ST_SDV_BIT = 4;
   localparam int ST_TRACE_BIT = 3;
   // ======================================================
   // Control register bit positions
   localparam int C0_MODE_HI_BIT = 7;
   localparam int C0_MODE_LO_BIT = 6;
   localparam int C0_PROG_BIT = 5;
   localparam int C0_RANGE1_BIT = 1;
   localparam int C0_RANGE0_BIT = 0;
   localparam int C1_DBE_BIT = 6;
   localparam int C1_MBH_BIT = 5;
   localparam int C1_MBL_BIT = 4;
   localparam int C1_DIR1_EN_BIT = 3;
   localparam int C1_DIR1_VAL_BIT = 2;
   localparam int C1_DIR0_EN_BIT = 1;
   localparam int C1_DIR0_VAL_BIT = 0;
   // ======================================================
   // Reset values
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;

   typedef enum logic [1:0] {
      GO_NONE,
      GO_RESUME,
      GO_STEP,
      GO_TAG
   } bdbrk_go_t;

   typedef enum logic [1:0] {
      BRK_OFF,
      BRK_SWI_DUAL,
      BRK_FULL,
      BRK_DBG_DUAL
   } bdbrk_mode_t;
endpackage : bdbrk_pkg

// ==== design/bdbrk_top.sv ====
// Background debug registers, firmware command handling, breakpoints
//
// Overview of operation
// - Go field: 00 none, 01 resume, 10 single step, 11 tag and resume.
// - Register field 010: X+=2 then transfer; 011: program counter.
// - Permit clear blocks background entry; hardware commands still work.
// - Active flag set while waiting for serial commands, else clear.
// - Tag-and-resume sets tagging flag; entry clears it; no commands then.
// - Shift-valid flag shows the shift register holds valid data.
// - Single-step command sets the trace flag.
// - 16-bit shift register, always readable and writable, also scratch.
// - 16-bit pointer, always readable, loaded only by debug hardware.
// - Entry saves condition codes in a holding register, also writable.
// - Mode select: off, dual SOFTWARE_INTERRUPT, single full debug, dual debug.
// - No breakpoint match while background mode is active.
// - SOFTWARE_INTERRUPT dual: fetch only, no direction or byte masks, only SOFTWARE_INTERRUPT source.
// - Dual modes: data enable arms second address compare on data regs.
// - Full mode ignores second range, direction value and enable.
// - Full mode data enable and byte masks only when program-only clear.
// - Dual debug: no byte masks; direction ignored when program-only set.
// - Program-only clear breaks at boundary; set tags the executed opcode.
// - Program-only set: data cycles never break; no meaning in SOFTWARE_INTERRUPT mode.
// - Second range bit includes low data-register byte in dual compare.
// - First range bit includes low address-register byte in compare.
// - Break address and data registers cleared by power-on reset only.
`timescale 1ns/1ps
`default_nettype none
module bdbrk_top (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic por_n,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic bd_map,
   input wire logic ser_cmd_valid,
   input wire logic [7:0] ser_cmd,
   input wire logic ser_shift_valid,
   input wire logic [15:0] ser_shift_data,
   input wire logic ser_addr_valid,
   input wire logic [15:0] ser_addr_data,
   input wire logic bg_enter_req,
   input wire logic [7:0] core_ccr,
   input wire logic core_step_done,
   input wire logic bus_valid,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_data,
   input wire logic bus_rnw,
   input wire logic bus_fetch,
   output logic debug_active,
   output logic tagging_on,
   output logic resume_pulse,
   output logic step_pulse,
   output logic fw_next_pulse,
   output logic fw_pc_pulse,
   output logic fw_dir_read,
   output logic [7:0] ccr_restore,
   output logic brk_req,
   output logic brk_tag,
   output logic swi_tag
);
   import bdbrk_pkg::*;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ======================================================
   // State
   logic [7:0] instr_r;
   logic permit_r;
   logic active_r;
   logic tag_r;
   logic sdv_r;
   logic trace_r;
   logic [15:0] shift_r;
   logic [15:0] ptr_r;
   logic [7:0] ccr_r;
   logic [7:0] ctl0_r;
   logic [7:0] ctl1_r;
   logic [15:0] brk_addr_r;
   logic [15:0] brk_data_r;

   // ======================================================
   // Command decode
   wire logic is_fw;
   bdbrk_go_t go_sel;
   wire logic sel_next;
   wire logic sel_pc;
   wire logic is_read;

   bdbrk_fwdec u_fwdec (
      .cmd(ser_cmd),
      .is_fw(is_fw),
      .go_sel(go_sel),
      .sel_next(sel_next),
      .sel_pc(sel_pc),
      .is_read(is_read)
   );

   // Tagging locks out all serial commands; shift and pointer loads still pass
   wire logic cmd_take = ser_cmd_valid && !tag_r;
   // Firmware runs only from the debug ROM, so it needs active mode
   wire logic fw_take = cmd_take && is_fw && active_r;
   wire logic go_resume = fw_take && (go_sel == GO_RESUME);
   wire logic go_step = fw_take && (go_sel == GO_STEP);
   wire logic go_tag = fw_take && (go_sel == GO_TAG);
   wire logic leave = go_resume || go_step || go_tag;
   wire logic step_back = trace_r && core_step_done && !active_r;
   wire logic enter = (bg_enter_req || step_back) && permit_r &&
                      !active_r;

   // ======================================================
   // Register decode
   wire logic dbg_vis = active_r || bd_map;
   wire logic wr_instr = reg_wr && dbg_vis && hit(reg_addr, DBG_INSTR_OFS);
   wire logic wr_stat = reg_wr && dbg_vis && hit(reg_addr, DBG_STATUS_OFS);
   wire logic wr_sh_hi = reg_wr && dbg_vis &&
                         hit(reg_addr, DBG_SHIFT_HI_OFS);
   wire logic wr_sh_lo = reg_wr && dbg_vis &&
                         hit(reg_addr, DBG_SHIFT_LO_OFS);
   wire logic wr_ccr = reg_wr && dbg_vis && hit(reg_addr, DBG_CCR_OFS);
   wire logic rd_sh_lo = reg_rd && dbg_vis &&
                         hit(reg_addr, DBG_SHIFT_LO_OFS);
   wire logic wr_c0 = reg_wr && hit(reg_addr, BRK_CTL0_OFS);
   wire logic wr_c1 = reg_wr && hit(reg_addr, BRK_CTL1_OFS);
   wire logic wr_ah = reg_wr && hit(reg_addr, BRK_ADDR_HI_OFS);
   wire logic wr_al = reg_wr && hit(reg_addr, BRK_ADDR_LO_OFS);
   wire logic wr_dh = reg_wr && hit(reg_addr, BRK_DATA_HI_OFS);
   wire logic wr_dl = reg_wr && hit(reg_addr, BRK_DATA_LO_OFS);

   wire logic [7:0] status_val = {permit_r, active_r, tag_r, sdv_r, trace_r,
                                  3'h0};

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = BYTE_RST;
      if (dbg_vis && hit(reg_addr, DBG_INSTR_OFS)) begin
         rd_mux = instr_r;
      end else if (dbg_vis && hit(reg_addr, DBG_STATUS_OFS)) begin
         rd_mux = status_val;
      end else if (dbg_vis && hit(reg_addr, DBG_SHIFT_HI_OFS)) begin
         rd_mux = shift_r[15:8];
      end else if (dbg_vis && hit(reg_addr, DBG_SHIFT_LO_OFS)) begin
         rd_mux = shift_r[7:0];
      end else if (dbg_vis && hit(reg_addr, DBG_PTR_HI_OFS)) begin
         rd_mux = ptr_r[15:8];
      end else if (dbg_vis && hit(reg_addr, DBG_PTR_LO_OFS)) begin
         rd_mux = ptr_r[7:0];
      end else if (dbg_vis && hit(reg_addr, DBG_CCR_OFS)) begin
         rd_mux = ccr_r;
      end else if (hit(reg_addr, BRK_CTL0_OFS)) begin
         rd_mux = ctl0_r;
      end else if (hit(reg_addr, BRK_CTL1_OFS)) begin
         rd_mux = ctl1_r;
      end else if (hit(reg_addr, BRK_ADDR_HI_OFS)) begin
         rd_mux = brk_addr_r[15:8];
      end else if (hit(reg_addr, BRK_ADDR_LO_OFS)) begin
         rd_mux = brk_addr_r[7:0];
      end else if (hit(reg_addr, BRK_DATA_HI_OFS)) begin
         rd_mux = brk_data_r[15:8];
      end else if (hit(reg_addr, BRK_DATA_LO_OFS)) begin
         rd_mux = brk_data_r[7:0];
      end
   end

   // ======================================================
   // Next values of the debug state
   wire logic active_nxt = enter ? 1'b1 : (leave ? 1'b0 : active_r);
   // Entry wins over a tag-and-resume in the same cycle
   wire logic tag_nxt = enter ? 1'b0 : (go_tag ? 1'b1 : tag_r);
   wire logic trace_nxt = go_step ? 1'b1 :
                          ((go_resume || go_tag) ? 1'b0 : trace_r);
   // Hardware set beats the firmware consume
   wire logic sdv_nxt = ser_shift_valid ? 1'b1 :
                        (rd_sh_lo || wr_sh_lo ? 1'b0 : sdv_r);
   wire logic [15:0] shift_nxt = ser_shift_valid ? ser_shift_data :
                                 {wr_sh_hi ? reg_wdata : shift_r[15:8],
                                  wr_sh_lo ? reg_wdata : shift_r[7:0]};
   wire logic [7:0] ccr_nxt = enter ? core_ccr :
                              (wr_ccr ? reg_wdata : ccr_r);
   wire logic [7:0] instr_nxt = cmd_take ? ser_cmd :
                                (wr_instr ? reg_wdata : instr_r);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         instr_r <= BYTE_RST;
         permit_r <= 1'b0;
         active_r <= 1'b0;
         tag_r <= 1'b0;
         sdv_r <= 1'b0;
         trace_r <= 1'b0;
         shift_r <= WORD_RST;
         ptr_r <= WORD_RST;
         ccr_r <= BYTE_RST;
      end else begin
         instr_r <= instr_nxt;
         permit_r <= wr_stat ? reg_wdata[ST_PERMIT_BIT] : permit_r;
         active_r <= active_nxt;
         tag_r <= tag_nxt;
         sdv_r <= sdv_nxt;
         trace_r <= trace_nxt;
         shift_r <= shift_nxt;
         // No software path into the pointer
         ptr_r <= ser_addr_valid ? ser_addr_data : ptr_r;
         ccr_r <= ccr_nxt;
      end
   end

   // ======================================================
   // Breakpoint registers; address and data survive normal resets
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctl0_r <= BYTE_RST;
         ctl1_r <= BYTE_RST;
      end else begin
         ctl0_r <= wr_c0 ? reg_wdata : ctl0_r;
         ctl1_r <= wr_c1 ? reg_wdata : ctl1_r;
      end
   end

   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         brk_addr_r <= WORD_RST;
         brk_data_r <= WORD_RST;
      end else begin
         brk_addr_r <= {wr_ah ? reg_wdata : brk_addr_r[15:8],
                        wr_al ? reg_wdata : brk_addr_r[7:0]};
         brk_data_r <= {wr_dh ? reg_wdata : brk_data_r[15:8],
                        wr_dl ? reg_wdata : brk_data_r[7:0]};
      end
   end

   // ======================================================
   // Breakpoint compare
   bdbrk_mode_t mode;
   assign mode = bdbrk_mode_t'({ctl0_r[C0_MODE_HI_BIT],
                               ctl0_r[C0_MODE_LO_BIT]});
   wire logic pm = ctl0_r[C0_PROG_BIT];
   wire logic dbe = ctl1_r[C1_DBE_BIT];
   wire logic is_swi = mode == BRK_SWI_DUAL;
   wire logic is_full = mode == BRK_FULL;
   wire logic is_dual = is_swi || (mode == BRK_DBG_DUAL);
   // SOFTWARE_INTERRUPT mode is always a fetch breakpoint, program-only meaningless there
   wire logic fetch_only = is_swi || pm;
   // Direction only counts off SOFTWARE_INTERRUPT mode and without program-only
   wire logic dir_ok = !is_swi && !pm;
   wire logic full_data = is_full && dbe && !pm;

   wire logic bp0_hit;
   wire logic bp1_hit;

   bdbrk_cmp u_bp0 (
      .ref_val(brk_addr_r),
      .cmp_val(bus_addr),
      .use_hi(1'b1),
      .use_lo(ctl0_r[C0_RANGE0_BIT]),
      .dir_en(dir_ok && ctl1_r[C1_DIR0_EN_BIT]),
      .dir_val(ctl1_r[C1_DIR0_VAL_BIT]),
      .bus_rnw(bus_rnw),
      .match(bp0_hit)
   );

   // Second unit: address compare in dual modes, data compare in full mode
   bdbrk_cmp u_bp1 (
      .ref_val(brk_data_r),
      .cmp_val(is_dual ? bus_addr : bus_data),
      .use_hi(is_dual || !ctl1_r[C1_MBH_BIT]),
      .use_lo(is_dual ? ctl0_r[C0_RANGE1_BIT] :
              !ctl1_r[C1_MBL_BIT]),
      .dir_en(is_dual && dir_ok && ctl1_r[C1_DIR1_EN_BIT]),
      .dir_val(ctl1_r[C1_DIR1_VAL_BIT]),
      .bus_rnw(bus_rnw),
      .match(bp1_hit)
   );

   // Compared on every bus cycle (fetches only in SOFTWARE_INTERRUPT mode or with program-only), never while background is active
   wire logic cyc_ok = bus_valid && !active_r &&
                       (!fetch_only || bus_fetch);
   wire logic dual_hit = bp0_hit || (dbe && bp1_hit);
   wire logic full_hit = bp0_hit && (!full_data || bp1_hit);
   wire logic any_hit = cyc_ok &&
                        (is_full ? full_hit : (is_dual && dual_hit));

   // ======================================================
   // Registered outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= BYTE_RST;
         debug_active <= 1'b0;
         tagging_on <= 1'b0;
         resume_pulse <= 1'b0;
         step_pulse <= 1'b0;
         fw_next_pulse <= 1'b0;
         fw_pc_pulse <= 1'b0;
         fw_dir_read <= 1'b0;
         ccr_restore <= BYTE_RST;
         brk_req <= 1'b0;
         brk_tag <= 1'b0;
         swi_tag <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : reg_rdata;
         debug_active <= active_nxt;
         tagging_on <= tag_nxt;
         resume_pulse <= go_resume || go_tag;
         step_pulse <= go_step;
         fw_next_pulse <= fw_take && sel_next;
         fw_pc_pulse <= fw_take && sel_pc;
         fw_dir_read <= fw_take ? is_read : fw_dir_read;
         ccr_restore <= ccr_nxt;
         // Immediate break at the next instruction boundary
         brk_req <= any_hit && !is_swi && !pm;
         // Tag rides the queue; breaks only if the opcode executes
         brk_tag <= any_hit && !is_swi && pm;
         swi_tag <= any_hit && is_swi;
      end
   end
endmodule : bdbrk_top
`default_nettype wire

// ==== verification/bdbrk_core_model.sv ====
// Core-side partner: answers single steps and shows condition codes
`timescale 1ns/1ps
`default_nettype none
module bdbrk_core_model #(
   parameter int STEP_WAIT = 3,
   parameter logic [7:0] CCR_VAL = 8'hA5
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic step_pulse,
   output logic core_step_done,
   output logic [7:0] core_ccr
);
   int cnt_r;
   // ======================================================
   // Step answer: one user instruction takes a few cycles
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 0;
      end else if (step_pulse) begin
         cnt_r <= STEP_WAIT;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   assign core_step_done = (cnt_r == 1);
   assign core_ccr = CCR_VAL;
endmodule : bdbrk_core_model
`default_nettype wire

// ==== verification/bdbrk_top_asserts.sv ====
// Concurrent checks on the debug and breakpoint block ports
`timescale 1ns/1ps
`default_nettype none
module bdbrk_chk (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ser_cmd_valid,
   input wire logic [7:0] ser_cmd,
   input wire logic bus_valid,
   input wire logic bus_fetch,
   input wire logic debug_active,
   input wire logic tagging_on,
   input wire logic resume_pulse,
   input wire logic step_pulse,
   input wire logic fw_next_pulse,
   input wire logic fw_pc_pulse,
   input wire logic fw_dir_read,
   input wire logic brk_req,
   input wire logic brk_tag,
   input wire logic swi_tag
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ======================================================
   // Firmware command accepted only while waiting in background
   wire fw_ok = ser_cmd_valid && !tagging_on && debug_active && !ser_cmd[7];
   wire any_go = resume_pulse || step_pulse || fw_next_pulse || fw_pc_pulse;
   a_go_resume: assert property (fw_ok && ser_cmd[4:3] == 2'h1
      |=> resume_pulse && !debug_active) else $error("resume missing");
   a_go_step: assert property (fw_ok && ser_cmd[4:3] == 2'h2
      |=> step_pulse && !resume_pulse) else $error("step missing");
   a_go_tag: assert property (fw_ok && ser_cmd[4:3] == 2'h3
      |=> resume_pulse && tagging_on) else $error("tag resume missing");
   a_go_none: assert property (fw_ok && ser_cmd[4:3] == 2'h0
      |=> !resume_pulse && !step_pulse && debug_active)
      else $error("idle go field acted");
   a_sel_next: assert property (fw_ok && ser_cmd[2:0] == 3'h2
      |=> fw_next_pulse && !fw_pc_pulse) else $error("next select bad");
   a_sel_pc: assert property (fw_ok && ser_cmd[2:0] == 3'h3
      |=> fw_pc_pulse && !fw_next_pulse) else $error("pc select bad");
   a_dir_read: assert property (fw_ok && ser_cmd[5]
      |=> fw_dir_read) else $error("read direction lost");
   a_cmd_refused: assert property (ser_cmd_valid
      && (tagging_on || !debug_active) |=> !any_go)
      else $error("refused command acted");
   a_bg_quiet: assert property (debug_active
      |=> !(brk_req || brk_tag || swi_tag)) else $error("break in background");
   a_swi_fetch: assert property (swi_tag
      |-> $past(bus_valid) && $past(bus_fetch)) else $error("swi not on fetch");
   a_brk_kind: assert property (brk_req
      |-> !brk_tag && !swi_tag) else $error("two break kinds at once");
   a_resume_once: assert property (resume_pulse
      |=> !resume_pulse) else $error("resume pulse too long");
endmodule : bdbrk_chk
bind bdbrk_top bdbrk_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
   .ser_cmd_valid(ser_cmd_valid), .ser_cmd(ser_cmd), .bus_valid(bus_valid),
   .bus_fetch(bus_fetch), .debug_active(debug_active),
   .tagging_on(tagging_on), .resume_pulse(resume_pulse),
   .step_pulse(step_pulse), .fw_next_pulse(fw_next_pulse),
   .fw_pc_pulse(fw_pc_pulse), .fw_dir_read(fw_dir_read), .brk_req(brk_req),
   .brk_tag(brk_tag), .swi_tag(swi_tag));
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the debug and breakpoint block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bdbrk_pkg::*;
   logic sys_clk = 1'h0, nrst = 1'h0, por_n = 1'h0, reg_wr = 1'h0;
   logic reg_rd = 1'h0, bd_map = 1'h0, ser_cmd_valid = 1'h0;
   logic ser_shift_valid = 1'h0, ser_addr_valid = 1'h0, bg_enter_req = 1'h0;
   logic bus_valid = 1'h0, bus_rnw = 1'h0, bus_fetch = 1'h0;
   logic [7:0] reg_wdata = 8'h0, ser_cmd = 8'h0, reg_rdata, core_ccr;
   logic [15:0] reg_addr = 16'h0, ser_shift_data = 16'h0, bus_addr = 16'h0;
   logic [15:0] ser_addr_data = 16'h0, bus_data = 16'h0;
   logic [7:0] ccr_restore;
   logic core_step_done, debug_active, tagging_on, resume_pulse, step_pulse;
   logic fw_next_pulse, fw_pc_pulse, fw_dir_read, brk_req, brk_tag, swi_tag;
   int bad_count = 0, comparisons = 0;
   bdbrk_top dut (.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bd_map(bd_map),
      .ser_cmd_valid(ser_cmd_valid), .ser_cmd(ser_cmd),
      .ser_shift_valid(ser_shift_valid), .ser_shift_data(ser_shift_data),
      .ser_addr_valid(ser_addr_valid), .ser_addr_data(ser_addr_data),
      .bg_enter_req(bg_enter_req), .core_ccr(core_ccr),
      .core_step_done(core_step_done), .bus_valid(bus_valid),
      .bus_addr(bus_addr), .bus_data(bus_data), .bus_rnw(bus_rnw),
      .bus_fetch(bus_fetch), .debug_active(debug_active),
      .tagging_on(tagging_on), .resume_pulse(resume_pulse),
      .step_pulse(step_pulse), .fw_next_pulse(fw_next_pulse),
      .fw_pc_pulse(fw_pc_pulse), .fw_dir_read(fw_dir_read),
      .ccr_restore(ccr_restore), .brk_req(brk_req), .brk_tag(brk_tag),
      .swi_tag(swi_tag));
   bdbrk_core_model model (.sys_clk(sys_clk), .nrst(nrst),
      .step_pulse(step_pulse), .core_step_done(core_step_done),
      .core_ccr(core_ccr));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // ======================================================
   // Shared helpers
   task automatic test_done();
      $display("mismatches %0d of %0d compares", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rdc(logic [15:0] a, logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      @(negedge sys_clk);
      check(reg_rdata, e);
   endtask : rdc
   task automatic cmd(logic [7:0] c);
      @(posedge sys_clk);
      ser_cmd <= c;
      ser_cmd_valid <= 1'h1;
      @(posedge sys_clk);
      ser_cmd_valid <= 1'h0;
      @(negedge sys_clk);
   endtask : cmd
   task automatic go_bg();
      @(posedge sys_clk);
      bg_enter_req <= 1'h1;
      @(posedge sys_clk);
      bg_enter_req <= 1'h0;
   endtask : go_bg
   // Bounded: a hung entry must not stall the run
   task automatic wait_act(logic e);
      int n;
      n = 0;
      while (debug_active !== e && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      check(debug_active, e);
      if (n == 50) test_done();
   endtask : wait_act
   // fw: {fetch, read}; e: {brk_req, brk_tag, swi_tag}
   task automatic bk(logic [7:0] c0, c1, logic [15:0] a, d,
                     logic [1:0] fw, logic [2:0] e);
      wr(BRK_CTL0_OFS, c0);
      wr(BRK_CTL1_OFS, c1);
      @(posedge sys_clk);
      bus_valid <= 1'h1;
      bus_addr <= a;
      bus_data <= d;
      {bus_fetch, bus_rnw} <= fw;
      @(posedge sys_clk);
      bus_valid <= 1'h0;
      @(negedge sys_clk);
      check({brk_req, brk_tag, swi_tag}, e);
   endtask : bk
   // ======================================================
   // Scenarios
   task automatic t_regs();
      rdc(DBG_STATUS_OFS, 8'h00);
      @(posedge sys_clk);
      bd_map <= 1'h1;
      wr(DBG_STATUS_OFS, 8'hFF);
      rdc(DBG_STATUS_OFS, 8'h80);
      wr(DBG_SHIFT_HI_OFS, 8'h5A);
      wr(DBG_SHIFT_LO_OFS, 8'hC3);
      rdc(DBG_SHIFT_HI_OFS, 8'h5A);
      rdc(DBG_SHIFT_LO_OFS, 8'hC3);
      wr(DBG_PTR_HI_OFS, 8'h77);
      rdc(DBG_PTR_HI_OFS, 8'h00);
      @(posedge sys_clk);
      ser_addr_valid <= 1'h1;
      ser_addr_data <= 16'hBEEF;
      ser_shift_valid <= 1'h1;
      ser_shift_data <= 16'h1234;
      @(posedge sys_clk);
      ser_addr_valid <= 1'h0;
      ser_shift_valid <= 1'h0;
      rdc(DBG_PTR_LO_OFS, 8'hEF);
      rdc(DBG_STATUS_OFS, 8'h90);
      rdc(DBG_SHIFT_LO_OFS, 8'h34);
      rdc(DBG_STATUS_OFS, 8'h80);
      rdc(16'h00FE, 8'h00);
      wr(BRK_ADDR_HI_OFS, 8'h12);
      wr(BRK_ADDR_LO_OFS, 8'h34);
      wr(BRK_DATA_HI_OFS, 8'h56);
      wr(BRK_DATA_LO_OFS, 8'h78);
   endtask : t_regs
   task automatic t_cmds();
      wr(DBG_STATUS_OFS, 8'h00);
      cmd(8'hC4);
      rdc(DBG_INSTR_OFS, 8'hC4);
      go_bg();
      repeat (3) @(negedge sys_clk);
      check(debug_active, 1'h0);
      wr(DBG_STATUS_OFS, 8'h80);
      go_bg();
      wait_act(1'h1);
      rdc(DBG_STATUS_OFS, 8'hC0);
      rdc(DBG_CCR_OFS, 8'hA5);
      wr(DBG_CCR_OFS, 8'h3C);
      rdc(DBG_CCR_OFS, 8'h3C);
      check(ccr_restore, 8'h3C);
      bk(8'h81, 8'h00, 16'h1234, 16'h0, 2'h1, 3'h0);
      cmd(8'h62);
      check({fw_next_pulse, fw_dir_read}, 2'h3);
      cmd(8'h43);
      check({fw_pc_pulse, fw_dir_read}, 2'h2);
      cmd(8'h00);
      check({resume_pulse, step_pulse, debug_active}, 3'h1);
      cmd(8'hE2);
      check(fw_next_pulse, 1'h0);
      cmd(8'h10);
      check(step_pulse, 1'h1);
      wait_act(1'h1);
      rdc(DBG_STATUS_OFS, 8'hC8);
      cmd(8'h18);
      check({resume_pulse, tagging_on, debug_active}, 3'h6);
      rdc(DBG_STATUS_OFS, 8'hA0);
      cmd(8'h08);
      check(resume_pulse, 1'h0);
      go_bg();
      wait_act(1'h1);
      check(tagging_on, 1'h0);
      cmd(8'h08);
      check({resume_pulse, debug_active}, 2'h2);
   endtask : t_cmds
   task automatic t_brk();
      bk(8'h00, 8'h00, 16'h1234, 16'h0, 2'h3, 3'h0);
      bk(8'h41, 8'h03, 16'h1234, 16'h0, 2'h3, 3'h1);
      bk(8'h41, 8'h00, 16'h1234, 16'h0, 2'h1, 3'h0);
      bk(8'h41, 8'h40, 16'h5678, 16'h0, 2'h3, 3'h1);
      bk(8'h41, 8'h00, 16'h5678, 16'h0, 2'h3, 3'h0);
      bk(8'h81, 8'h00, 16'h1234, 16'h0, 2'h1, 3'h4);
      bk(8'h80, 8'h00, 16'h12FF, 16'h0, 2'h1, 3'h4);
      bk(8'h81, 8'h00, 16'h12FF, 16'h0, 2'h1, 3'h0);
      bk(8'h81, 8'h40, 16'h1234, 16'h5600, 2'h1, 3'h0);
      bk(8'h83, 8'h50, 16'h1234, 16'h5600, 2'h1, 3'h4);
      bk(8'h81, 8'h60, 16'h1234, 16'h0078, 2'h1, 3'h4);
      bk(8'hA1, 8'h40, 16'h1234, 16'h0, 2'h3, 3'h2);
      bk(8'hA1, 8'h40, 16'h1234, 16'h0, 2'h1, 3'h0);
      bk(8'h81, 8'h0C, 16'h1234, 16'h0, 2'h0, 3'h4);
      bk(8'hC3, 8'h40, 16'h5678, 16'h0, 2'h1, 3'h4);
      bk(8'hC3, 8'h00, 16'h5678, 16'h0, 2'h1, 3'h0);
      bk(8'hC1, 8'h40, 16'h56FF, 16'h0, 2'h1, 3'h4);
      bk(8'hC3, 8'h40, 16'h56FF, 16'h0, 2'h1, 3'h0);
      bk(8'hC3, 8'h4C, 16'h5678, 16'h0, 2'h0, 3'h0);
      bk(8'hE3, 8'h4C, 16'h5678, 16'h0, 2'h2, 3'h2);
      bk(8'hC3, 8'h70, 16'h5678, 16'h0, 2'h1, 3'h4);
   endtask : t_brk
   // Plain reset keeps the break registers; power-on clears them
   task automatic t_rst();
      @(posedge sys_clk);
      nrst <= 1'h0;
      @(posedge sys_clk);
      nrst <= 1'h1;
      rdc(BRK_ADDR_LO_OFS, 8'h34);
      @(posedge sys_clk);
      nrst <= 1'h0;
      por_n <= 1'h0;
      @(posedge sys_clk);
      nrst <= 1'h1;
      por_n <= 1'h1;
      rdc(BRK_DATA_HI_OFS, 8'h00);
   endtask : t_rst
   initial begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'h1;
      por_n <= 1'h1;
      t_regs();
      t_cmds();
      t_brk();
      t_rst();
      test_done();
   end
endmodule : testbench
`default_nettype wire
